//--- pmic_control_flag_enable_regs.sv
`timescale 1ns/1ps
`include "pmic_regs_cfg.svh"
// Notes on behaviour
// - Power-fail select 0 ignores comparator; 1 shuts all rails except bucks 5 and 6 off on trip while active or in suspend.
// - Writing 1 to coin trigger starts one measurement; bit self-clears; 0 ignored.
// - Wake flag register at 0x07, resets 0x00, read-only, eight rail flags.
// - Converter flag reads 0 after power-up from off or rail off in suspend.
// - Converter flag reads 1 only when rail stayed on through suspend.
// - General output flag mirrors its suspend enable after leaving suspend.
// - Linear regulator flag set only after suspend wake with regulator on.
// - Unlock register at 0x10 accepts byte writes to open protected access.
// - Reading unlock register always returns 0x00.
// - Converter enable register at 0x11, resets 0x00, writable only when unlocked.
// - Converter enable bits 7-6 read zero; bits 5-0 enable bucks 6..1.
// - Clearing buck 6 enable works only while fresh seal status is 0.
// - Clearing buck 5 enable works only while fresh seal status is 0.
// - Sequencer sets and clears bucks 1-5, switch 1 and linear regulator.
// - Switch enable register at 0x12, resets 0x00, writable only when unlocked.
// - Bit 7 reserved; 6-4 general outputs; 3-1 switches; 0 linear regulator.
// - Control register at 0x06, resets 0x00.
// - Fresh seal status 0 while intact, 1 once broken.
module pmic_control_flag_enable_regs (
    input  wire logic       mclk_i,
    input  wire logic       rst_n_i,
    input  wire logic [7:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    output logic      [7:0] reg_rdata_o,
    input  wire logic       unlock_ok_i,
    input  wire logic       fresh_seal_status_i,
    input  wire logic       power_fail_out_n_i,
    input  wire logic       seq_update_i,
    input  wire logic [5:0] seq_buck_on_i,
    input  wire logic       seq_switch1_on_i,
    input  wire logic       seq_linreg_on_i,
    input  wire logic       enter_suspend_i,
    input  wire logic       wake_i,
    output logic      [7:0] unlock_code_o,
    output logic            unlock_wr_o,
    output logic            coin_measure_start_o,
    output logic            power_fail_shutdown_o,
    output logic            power_fail_shutdown_sel_o,
    output logic      [5:0] buck_on_o,
    output logic      [2:0] gen_out_level_o,
    output logic      [2:0] switch_on_o,
    output logic            linreg_on_o,
    output pmic_regs_pkg::pwr_state_t pwr_state_o
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [7:0]                control;
        logic [7:0]                conv_en;
        logic [7:0]                sw_en;
        logic [7:0]                rdata;
        logic [7:0]                unlock_code;
        logic                      unlock_wr;
        logic                      coin_start;
        logic                      pf_shutdown;
        pmic_regs_pkg::pwr_state_t pwr;
    } regs_state_t;

    regs_state_t st;
    regs_state_t next_st;
    logic [7:0]  wake_flags;
    logic        wake_from_susp;
    logic        wake_from_off;
    logic [7:0]  susp_on;
    logic        pf_trip;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        hit = (a == b);
    endfunction

    // Snapshot of rail enables as held during suspend
    assign susp_on = {st.sw_en[6:4], st.sw_en[0], st.conv_en[3:0]};
    assign wake_from_susp = wake_i && (st.pwr == pmic_regs_pkg::PWR_SUSPEND);
    assign wake_from_off  = wake_i && (st.pwr == pmic_regs_pkg::PWR_OFF);

    // Live states only, so a held trip cannot pin us in shutdown
    assign pf_trip = st.control[`BIT_PF_SEL] && !power_fail_out_n_i
                     && (st.pwr == pmic_regs_pkg::PWR_ACTIVE || st.pwr == pmic_regs_pkg::PWR_SUSPEND);

    wake_flag_capture u_flags (
        .mclk_i           (mclk_i),
        .rst_n_i          (rst_n_i),
        .wake_from_off_i  (wake_from_off),
        .wake_from_susp_i (wake_from_susp),
        .susp_on_i        (susp_on),
        .flags_o          (wake_flags)
    );

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        logic [7:0] wr;
        wr = reg_wdata_i;
        next_st = st;
        next_st.unlock_wr   = 1'b0;
        next_st.coin_start  = 1'b0;
        next_st.pf_shutdown = 1'b0;
        next_st.control[`BIT_COIN_TRIG] = 1'b0;

        if (reg_wr_i) begin
            if (hit(reg_addr_i, `ADDR_CONTROL)) begin
                next_st.control = wr & `MASK_CONTROL & ~8'h01;
                next_st.coin_start = wr[`BIT_COIN_TRIG];
            end else if (hit(reg_addr_i, `ADDR_UNLOCK)) begin
                next_st.unlock_code = wr;
                next_st.unlock_wr   = 1'b1;
            end else if (hit(reg_addr_i, `ADDR_CONV_EN) && unlock_ok_i) begin
                next_st.conv_en = wr & `MASK_CONV_EN;
                // Backup bucks stay on once the seal is broken
                if (fresh_seal_status_i && st.conv_en[`BIT_BUCK6]) begin
                    next_st.conv_en[`BIT_BUCK6] = 1'b1;
                end
                if (fresh_seal_status_i && st.conv_en[`BIT_BUCK5]) begin
                    next_st.conv_en[`BIT_BUCK5] = 1'b1;
                end
            end else if (hit(reg_addr_i, `ADDR_SW_EN) && unlock_ok_i) begin
                next_st.sw_en = wr & `MASK_SW_EN;
            end
        end

        // Sequencer has the last word over host writes
        if (seq_update_i) begin
            next_st.conv_en[4:0] = seq_buck_on_i[4:0];
            if (fresh_seal_status_i && st.conv_en[`BIT_BUCK5]) begin
                next_st.conv_en[`BIT_BUCK5] = 1'b1;
            end
            next_st.sw_en[`BIT_SWITCH1] = seq_switch1_on_i;
            next_st.sw_en[`BIT_LINREG]  = seq_linreg_on_i;
        end

        case (st.pwr)
            pmic_regs_pkg::PWR_OFF: begin
                if (wake_i) next_st.pwr = pmic_regs_pkg::PWR_ACTIVE;
            end
            pmic_regs_pkg::PWR_ACTIVE: begin
                if (enter_suspend_i) next_st.pwr = pmic_regs_pkg::PWR_SUSPEND;
            end
            pmic_regs_pkg::PWR_SUSPEND: begin
                if (wake_i) next_st.pwr = pmic_regs_pkg::PWR_ACTIVE;
            end
            pmic_regs_pkg::PWR_SHUTDN: begin
                next_st.pwr = pmic_regs_pkg::PWR_OFF;
            end
            default: begin
                next_st.pwr = pmic_regs_pkg::PWR_OFF;
            end
        endcase

        // Power-fail trip overrides host and sequencer enable updates and the state
        if (pf_trip) begin
            next_st.pf_shutdown = 1'b1;
            next_st.pwr = pmic_regs_pkg::PWR_SHUTDN;
            next_st.conv_en = st.conv_en & 8'h30;
            next_st.sw_en = 8'h00;
        end

        next_st.rdata = 8'h00;
        if (reg_rd_i) begin
            case (reg_addr_i)
                `ADDR_CONTROL:    next_st.rdata = st.control & `MASK_CONTROL;
                `ADDR_WAKE_FLAGS: next_st.rdata = wake_flags;
                `ADDR_UNLOCK:     next_st.rdata = `UNLOCK_READ_VAL;
                `ADDR_CONV_EN:    next_st.rdata = st.conv_en & `MASK_CONV_EN;
                `ADDR_SW_EN:      next_st.rdata = st.sw_en & `MASK_SW_EN;
                default:          next_st.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st.control     <= `RST_CONTROL;
            st.conv_en     <= `RST_CONV_EN;
            st.sw_en       <= `RST_SW_EN;
            st.rdata       <= 8'h00;
            st.unlock_code <= 8'h00;
            st.unlock_wr   <= 1'b0;
            st.coin_start  <= 1'b0;
            st.pf_shutdown <= 1'b0;
            st.pwr         <= pmic_regs_pkg::PWR_OFF;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign reg_rdata_o               = st.rdata;
    assign unlock_code_o             = st.unlock_code;
    assign unlock_wr_o               = st.unlock_wr;
    assign coin_measure_start_o      = st.coin_start;
    assign power_fail_shutdown_o     = st.pf_shutdown;
    assign power_fail_shutdown_sel_o = st.control[`BIT_PF_SEL];
    assign buck_on_o                 = st.conv_en[5:0];
    assign gen_out_level_o           = st.sw_en[6:4];
    assign switch_on_o               = st.sw_en[3:1];
    assign linreg_on_o               = st.sw_en[`BIT_LINREG];
    assign pwr_state_o               = st.pwr;

    // ----------------------------------------
    // Checks: power-fail path
    // ----------------------------------------
    a_pf_trip_off: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        pf_trip
        |=> power_fail_shutdown_o && buck_on_o[3:0] == 4'h0
        ##1 pwr_state_o == pmic_regs_pkg::PWR_OFF)
        else $error("power-fail trip did not shut down");

    a_pf_rails_off: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        pf_trip
        |=> switch_on_o == 3'b000 && !linreg_on_o && gen_out_level_o == 3'b000)
        else $error("power-fail trip left switches or outputs on");

    a_pf_ignored: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        !st.control[1]
        |=> !power_fail_shutdown_o)
        else $error("power-fail acted while not selected");

    a_shutdn_exit: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        pwr_state_o == pmic_regs_pkg::PWR_SHUTDN
        |=> pwr_state_o == pmic_regs_pkg::PWR_OFF)
        else $error("shutdown did not reach off");

    // ----------------------------------------
    // Checks: control, unlock and wake flags
    // ----------------------------------------
    a_coin_pulse: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        reg_wr_i && reg_addr_i == 8'h06 && reg_wdata_i[0]
        |=> coin_measure_start_o ##1 !coin_measure_start_o)
        else $error("coin trigger not a single pulse");

    a_coin_no_zero: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        !(reg_wr_i && reg_addr_i == 8'h06 && reg_wdata_i[0])
        |=> !coin_measure_start_o)
        else $error("coin measurement started without a trigger write");

    a_coin_selfclr: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        st.control[0] == 1'b0)
        else $error("coin trigger bit did not self clear");

    a_unlock_reads: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        reg_rd_i && reg_addr_i == 8'h10
        |=> reg_rdata_o == 8'h00)
        else $error("unlock register read nonzero");

    a_unlock_strobe: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        reg_wr_i && reg_addr_i == 8'h10
        |=> unlock_wr_o && unlock_code_o == $past(reg_wdata_i))
        else $error("unlock byte not passed on");

    a_flags_read: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        reg_rd_i && reg_addr_i == 8'h07
        |=> reg_rdata_o == $past(wake_flags))
        else $error("wake flag read did not return the flags");

    a_flags_ro: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        reg_wr_i && reg_addr_i == 8'h07 && !wake_i
        |=> $stable(wake_flags))
        else $error("write changed the wake flags");

    // ----------------------------------------
    // Checks: enable registers
    // ----------------------------------------
    a_locked_write: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        reg_wr_i && reg_addr_i == 8'h11 && !unlock_ok_i && !seq_update_i && !pf_trip
        |=> $stable(buck_on_o))
        else $error("locked write changed converter enables");

    a_locked_sw: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        reg_wr_i && reg_addr_i == 8'h12 && !unlock_ok_i && !seq_update_i && !pf_trip
        |=> $stable({gen_out_level_o, switch_on_o, linreg_on_o}))
        else $error("locked write changed switch enables");

    a_buck6_keep: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        buck_on_o[5] && fresh_seal_status_i
        |=> buck_on_o[5])
        else $error("backup buck 6 cleared with seal broken");

    a_buck5_keep: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        buck_on_o[4] && fresh_seal_status_i
        |=> buck_on_o[4])
        else $error("backup buck 5 cleared with seal broken");

    a_reserved_zero: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        st.conv_en[7:6] == 2'b00 && st.sw_en[7] == 1'b0 && st.control[7:2] == 6'h00)
        else $error("reserved bits set");

    a_seq_switch1: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        seq_update_i && !pf_trip
        |=> switch_on_o[0] == $past(seq_switch1_on_i) && linreg_on_o == $past(seq_linreg_on_i))
        else $error("sequencer did not update switch 1");

    a_seq_bucks: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        seq_update_i && !pf_trip
        |=> buck_on_o[3:0] == $past(seq_buck_on_i[3:0]))
        else $error("sequencer did not update bucks 1 to 4");

    c_coin_start: cover property (@(posedge mclk_i) coin_measure_start_o);
    c_pf_shutdown: cover property (@(posedge mclk_i) power_fail_shutdown_o);
    c_susp_wake: cover property (@(posedge mclk_i) wake_from_susp ##1 wake_flags != 8'h00);
    c_seq_update: cover property (@(posedge mclk_i) seq_update_i && !pf_trip);
    c_locked_try: cover property (@(posedge mclk_i) reg_wr_i && reg_addr_i == 8'h11 && !unlock_ok_i);
endmodule

//--- pmic_regs_cfg.svh
`ifndef PMIC_REGS_CFG_SVH
`define PMIC_REGS_CFG_SVH
// ----------------------------------------
// Register subaddresses
// ----------------------------------------
`define ADDR_CONTROL     8'h06
`define ADDR_WAKE_FLAGS  8'h07
`define ADDR_UNLOCK      8'h10
`define ADDR_CONV_EN     8'h11
`define ADDR_SW_EN       8'h12
// ----------------------------------------
// Reset values and masks
// ----------------------------------------
`define RST_CONTROL      8'h00
`define RST_WAKE_FLAGS   8'h00
`define RST_CONV_EN      8'h00
`define RST_SW_EN        8'h00
`define UNLOCK_READ_VAL  8'h00
`define MASK_CONTROL     8'h03
`define MASK_CONV_EN     8'h3f
`define MASK_SW_EN       8'h7f
// ----------------------------------------
// Field positions
// ----------------------------------------
`define BIT_COIN_TRIG    0
`define BIT_PF_SEL       1
`define BIT_BUCK5        4
`define BIT_BUCK6        5
`define BIT_LINREG       0
`define BIT_SWITCH1      1
`endif

//--- pmic_regs_pkg.sv
package pmic_regs_pkg;
    typedef enum logic [3:0] {
        PWR_OFF     = 4'b0001,
        PWR_ACTIVE  = 4'b0010,
        PWR_SUSPEND = 4'b0100,
        PWR_SHUTDN  = 4'b1000
    } pwr_state_t;
endpackage

//--- wake_flag_capture.sv
`timescale 1ns/1ps
`include "pmic_regs_cfg.svh"
module wake_flag_capture (
    input  wire logic       mclk_i,
    input  wire logic       rst_n_i,
    input  wire logic       wake_from_off_i,
    input  wire logic       wake_from_susp_i,
    input  wire logic [7:0] susp_on_i,
    output logic      [7:0] flags_o
);
    typedef struct packed {
        logic [7:0] flags;
    } flag_state_t;

    flag_state_t st;
    flag_state_t next_st;

    always_comb begin
        next_st = st;
        if (wake_from_off_i) begin
            next_st.flags = 8'h00;
        end else if (wake_from_susp_i) begin
            next_st.flags = susp_on_i;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st.flags <= `RST_WAKE_FLAGS;
        end else begin
            st <= next_st;
        end
    end

    assign flags_o = st.flags;

    a_flag_wake_susp: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        wake_from_susp_i && !wake_from_off_i |=> flags_o == $past(susp_on_i))
        else $error("wake flags not captured from suspend");
    a_flag_wake_off: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        wake_from_off_i |=> flags_o == 8'h00)
        else $error("wake flags not cleared on power-up from off");
endmodule

//--- host_model.sv
`timescale 1ns/1ps
module host_model (
    input  wire logic       mclk_i,
    input  wire logic [7:0] reg_rdata_i,
    output logic      [7:0] reg_addr_o,
    output logic      [7:0] reg_wdata_o,
    output logic            reg_wr_o,
    output logic            reg_rd_o,
    output logic            unlock_ok_o
);
    // ----------------------------------------
    // Bus cycles, driven on the falling edge
    // ----------------------------------------
    initial begin
        reg_addr_o  = 8'h00;
        reg_wdata_o = 8'h00;
        reg_wr_o    = 1'b0;
        reg_rd_o    = 1'b0;
        unlock_ok_o = 1'b0;
    end

    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data, input logic unlock);
        @(negedge mclk_i);
        unlock_ok_o = unlock; // Unlock just before the protected write
        reg_addr_o  = addr;
        reg_wdata_o = data;
        reg_wr_o    = 1'b1;
        @(negedge mclk_i);
        reg_wr_o    = 1'b0;
        unlock_ok_o = 1'b0; // Relock, never left open between writes
        reg_addr_o  = ~addr; // Released lines move, stale values cannot pass
        reg_wdata_o = ~data;
    endtask

    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        @(negedge mclk_i);
        reg_addr_o = addr;
        reg_rd_o   = 1'b1;
        @(negedge mclk_i);
        reg_rd_o   = 1'b0;
        data       = reg_rdata_i;
        reg_addr_o = ~addr;
    endtask
endmodule

//--- tb.sv
`timescale 1ns/1ps
module tb;
    logic       mclk_i;
    logic       rst_n_i;
    logic [7:0] reg_addr, reg_wdata, rdata, unlock_code;
    logic       reg_wr, reg_rd, unlock_ok, seal, pf_n, seq_upd, seq_sw1, seq_ldo, susp, wake;
    logic       coin_start, pf_shut, pf_sel, unlock_wr, linreg;
    logic [2:0] gen_out, sw_on;
    logic [5:0] seq_buck, buck_on;
    pmic_regs_pkg::pwr_state_t pwr;
    int         failures;
    int         samples_checked;
    logic [7:0] reset_addrs [5] = '{8'h06, 8'h07, 8'h10, 8'h11, 8'h12};

    host_model host_model_i (.mclk_i(mclk_i), .reg_rdata_i(rdata), .reg_addr_o(reg_addr),
        .reg_wdata_o(reg_wdata), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .unlock_ok_o(unlock_ok));

    pmic_control_flag_enable_regs pmic_control_flag_enable_regs_i (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
        .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(rdata), .unlock_ok_i(unlock_ok),
        .fresh_seal_status_i(seal), .power_fail_out_n_i(pf_n), .seq_update_i(seq_upd),
        .seq_buck_on_i(seq_buck), .seq_switch1_on_i(seq_sw1), .seq_linreg_on_i(seq_ldo),
        .enter_suspend_i(susp), .wake_i(wake), .unlock_code_o(unlock_code), .unlock_wr_o(unlock_wr),
        .coin_measure_start_o(coin_start), .power_fail_shutdown_o(pf_shut),
        .power_fail_shutdown_sel_o(pf_sel), .buck_on_o(buck_on), .gen_out_level_o(gen_out),
        .switch_on_o(sw_on), .linreg_on_o(linreg), .pwr_state_o(pwr));

    // ----------------------------------------
    // Checking and closing
    // ----------------------------------------
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] d;
        host_model_i.read_reg(addr, d);
        chk($sformatf("reg %h", addr), exp, d);
    endtask

    task automatic wr(input logic [7:0] addr, input logic [7:0] data, input logic unlock);
        host_model_i.write_reg(addr, data, unlock);
    endtask

    task automatic give_verdict;
        $display("Checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        mclk_i = 1'b0;
        forever #2.5 mclk_i = ~mclk_i;
    end

    initial begin
        repeat (5000) @(posedge mclk_i);
        failures++;
        give_verdict;
    end

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        failures = 0;
        samples_checked = 0;
        rst_n_i = 1'b0;
        {seal, seq_upd, seq_sw1, seq_ldo, susp, wake} = 6'h00;
        pf_n = 1'b1;
        seq_buck = 6'h00;
        repeat (2) @(posedge mclk_i);
        @(negedge mclk_i);
        rst_n_i = 1'b1;
        foreach (reset_addrs[i]) rd_chk(reset_addrs[i], 8'h00);
        wr(8'h11, 8'hff, 1'b0);
        rd_chk(8'h11, 8'h00);
        wr(8'h12, 8'hff, 1'b0);
        rd_chk(8'h12, 8'h00);
        wr(8'h11, 8'hff, 1'b1);
        chk("buck_on", 8'h3f, {2'b00, buck_on});
        rd_chk(8'h11, 8'h3f);
        wr(8'h12, 8'hff, 1'b1);
        chk("sw_outputs", 8'h7f, {1'b0, gen_out, sw_on, linreg});
        rd_chk(8'h12, 8'h7f);
        seal = 1'b1;
        wr(8'h11, 8'h00, 1'b1);
        rd_chk(8'h11, 8'h30);
        seal = 1'b0;
        wr(8'h11, 8'h05, 1'b1);
        rd_chk(8'h11, 8'h05);
        wr(8'h10, 8'ha5, 1'b0);
        chk("unlock_code", 8'ha5, unlock_code);
        chk("unlock_wr", 8'h01, {7'h00, unlock_wr});
        rd_chk(8'h10, 8'h00);
        wr(8'h06, 8'h01, 1'b0);
        chk("coin_start", 8'h01, {7'h00, coin_start});
        rd_chk(8'h06, 8'h00);
        chk("coin_start_end", 8'h00, {7'h00, coin_start});
        // Leave OFF so the comparator has a live state to act on
        wake = 1'b1;
        @(negedge mclk_i);
        wake = 1'b0;
        pf_n = 1'b0;
        repeat (2) @(negedge mclk_i);
        pf_n = 1'b1;
        chk("state_sel0", {4'h0, pmic_regs_pkg::PWR_ACTIVE}, {4'h0, pwr});
        wr(8'h06, 8'hfe, 1'b0);
        rd_chk(8'h06, 8'h02);
        chk("pf_sel", 8'h01, {7'h00, pf_sel});
        wr(8'h12, 8'h51, 1'b1);
        susp = 1'b1;
        @(negedge mclk_i);
        susp = 1'b0;
        wake = 1'b1;
        @(negedge mclk_i);
        wake = 1'b0;
        rd_chk(8'h07, 8'hb5);
        wr(8'h07, 8'h00, 1'b1);
        rd_chk(8'h07, 8'hb5);
        pf_n = 1'b0;
        @(negedge mclk_i);
        pf_n = 1'b1;
        chk("pf_shut", 8'h01, {7'h00, pf_shut});
        chk("rails_off", 8'h00, {1'b0, gen_out, sw_on, linreg});
        chk("state_shut", {4'h0, pmic_regs_pkg::PWR_SHUTDN}, {4'h0, pwr});
        @(negedge mclk_i);
        chk("state_off", {4'h0, pmic_regs_pkg::PWR_OFF}, {4'h0, pwr});
        rd_chk(8'h11, 8'h00);
        wake = 1'b1;
        @(negedge mclk_i);
        wake = 1'b0;
        rd_chk(8'h07, 8'h00);
        {seq_buck, seq_sw1, seq_ldo, seq_upd} = {6'h3f, 3'b111};
        @(negedge mclk_i);
        seq_upd = 1'b0;
        chk("seq_rails", 8'h03, {1'b0, gen_out, sw_on, linreg});
        rd_chk(8'h11, 8'h1f);
        rd_chk(8'h12, 8'h03);
        give_verdict;
    end
endmodule
